// ===== logic/cdpa_defs.vh
/*
 constants for the scratch-pad, password and diagnostic status logic.
 assumes it is included by name from logic/cdpa_core.v, the assertion checker and the bench.

// Summary of operation
// - scratch-pad words: mode 0000, subcommand 0002, result 0004, password 000a, type 0016.
// - subcommand 0009 login, 0003 grammar check, 0006 error address, 000a change password.
// - with a password set, types 1, 3, 7 need a login per request.
// - password is BCD 0 to 9999; zero means protection off.
// - subcommand low byte arrives in word high byte; password keeps byte order.
// - password change needs prior login, then change subcommand, zeros, new password.
// - subcommand 0003 runs program check; result word holds zero or error code.
// - subcommand 0006 loads result word with first error location.
// - five diagnostic words as type 9; read from 0 covering all; write clears.
// - diagnostic word 1: newest code in high byte, previous in low byte.
// - words 2 to 5 count good, aborted conversations, header and block retries.
// - code 00 for success, 01 for serial link timeout.
// - refusal codes 02, 03, 04, 06, 09, 0a, 0b for invalid accesses.
// - code 05 for odd byte count on word memories, 07 for zero length.
// - code 08 for protected writes: user logic in run, or locked access.
// - abort after third failed retry: 0c for data blocks, 0d for headers.
// - code 0f when header unit address disagrees with matched enquiry.
// - code 14 bad block framing, 1e header character error, 1f block character error.
// - code 15 missing end of transmission, 16 missing acknowledge.
// - code 1a transmit held off by inactive clear-to-send, 1d controller transfer failure.
*/
`ifndef CDPA_DEFS_VH
`define CDPA_DEFS_VH
`define CDPA_SP_MODE    16'h0000
`define CDPA_SP_SUBCMD  16'h0002
`define CDPA_SP_RESULT  16'h0004
`define CDPA_SP_PWD     16'h000a
`define CDPA_SP_TYPE    16'h0016
`define CDPA_SP_WR_END  17'h0000c
`define CDPA_SUB_LOGIN  16'h0009
`define CDPA_SUB_CHECK  16'h0003
`define CDPA_SUB_ERRLOC 16'h0006
`define CDPA_SUB_CHPWD  16'h000a
`define CDPA_MT_TC      4'h1
`define CDPA_MT_IO      4'h3
`define CDPA_MT_SP      4'h6
`define CDPA_MT_USER    4'h7
`define CDPA_MT_DIAG    4'h9
`define CDPA_TC_WORDS   17'h00080
`define CDPA_IO_BYTES   17'h00070
`define CDPA_USER_WORDS 17'h00800
`define CDPA_DIAG_BYTES 16'h000a
`define CDPA_RETRY_MAX  2'd3
`define CDPA_CTRL_TYPE  16'h0001
`define CDPA_E_OK       8'h00
`define CDPA_E_TMO      8'h01
`define CDPA_E_SPWR     8'h02
`define CDPA_E_IOPT     8'h03
`define CDPA_E_SIZE     8'h04
`define CDPA_E_ODD      8'h05
`define CDPA_E_TCREG    8'h06
`define CDPA_E_ZERO     8'h07
`define CDPA_E_PROT     8'h08
`define CDPA_E_MTYPE    8'h09
`define CDPA_E_DIAG     8'h0a
`define CDPA_E_START    8'h0b
`define CDPA_E_BLKABT   8'h0c
`define CDPA_E_HDRABT   8'h0d
`define CDPA_E_UNIT     8'h0f
`define CDPA_E_BLKBAD   8'h14
`define CDPA_E_NOEOT    8'h15
`define CDPA_E_NOACK    8'h16
`define CDPA_E_CTS      8'h1a
`define CDPA_E_CPU      8'h1d
`define CDPA_E_HDRCHR   8'h1e
`define CDPA_E_BLKCHR   8'h1f
`endif

// ===== logic/cdpa_core.v
/*
 request checking, password login, program check and diagnostic status words.
 assumes a protocol engine and program checker on core_clk driving the
 request, scratch-pad and event ports; all inputs are same-clock logic.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cdpa_defs.vh"
module cdpa_core (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire [3:0]  req_mem_type,
    input  wire [15:0] req_addr,
    input  wire [15:0] req_len,
    output reg         req_ack,
    output reg  [7:0]  req_code,
    input  wire        sp_wr,
    input  wire [15:0] sp_addr,
    input  wire [15:0] sp_data,
    input  wire        rd_en,
    input  wire [3:0]  rd_type,
    input  wire [15:0] rd_addr,
    output reg  [15:0] rd_data,
    input  wire        diag_clear,
    output reg         chk_start,
    input  wire        chk_done,
    input  wire [15:0] chk_code,
    input  wire [15:0] chk_err_loc,
    input  wire        hdr_fail,
    input  wire        blk_fail,
    output reg         conv_abort,
    input  wire        conv_start,
    input  wire        conv_end,
    input  wire [9:0]  link_err,
    output reg         lock_active,
    output reg         run_mode
);

    localparam SEQ_IDLE  = 4'b0001;
    localparam SEQ_LOGIN = 4'b0010;
    localparam SEQ_CHPWD = 4'b0100;
    localparam SEQ_CHECK = 4'b1000;

    reg  [3:0]  seq_reg;
    reg  [15:0] mode_reg;
    reg  [15:0] result_reg;
    reg  [15:0] pwd_reg;
    reg         login_reg;
    reg  [7:0]  pend_code_reg;
    reg  [1:0]  hdr_try_reg;
    reg  [1:0]  blk_try_reg;
    reg  [15:0] diag_reg [0:4];
    wire [15:0] sub_word;
    wire        locked;
    wire        hdr_abort;
    wire        blk_abort;
    wire        conv_fin;
    wire [7:0]  req_chk;
    wire [7:0]  link_code;
    reg  [7:0]  fin_code;
    wire [4:1]  diag_inc;

    // checks one request header, returns zero when it may proceed
    function [7:0] check_req;
        input        wr;
        input [3:0]  mt;
        input [15:0] ad;
        input [15:0] ln;
        input        lk;
        input        run;
        reg   [16:0] end_b;
        reg   [16:0] end_w;
        begin
            end_b = {1'b0, ad} + {1'b0, ln};
            end_w = {1'b0, ad} + {2'b00, ln[15:1]};
            check_req = `CDPA_E_OK;
            if (ln == 16'h0000)
                check_req = `CDPA_E_ZERO;
            else if (mt != `CDPA_MT_TC && mt != `CDPA_MT_IO && mt != `CDPA_MT_SP
                     && mt != `CDPA_MT_USER && mt != `CDPA_MT_DIAG)
                check_req = `CDPA_E_MTYPE;
            else if (ln[0] && (mt == `CDPA_MT_TC || mt == `CDPA_MT_USER || mt == `CDPA_MT_DIAG))
                check_req = `CDPA_E_ODD;
            else if (lk && (mt == `CDPA_MT_TC || mt == `CDPA_MT_IO || mt == `CDPA_MT_USER))
                check_req = `CDPA_E_PROT;
            else if (mt == `CDPA_MT_DIAG && (ad != 16'h0000 || (!wr && ln != `CDPA_DIAG_BYTES)
                     || ln > `CDPA_DIAG_BYTES))
                check_req = `CDPA_E_DIAG;
            else if (mt == `CDPA_MT_SP && (ad[0] || ad > `CDPA_SP_TYPE))
                check_req = `CDPA_E_START;
            else if (mt == `CDPA_MT_SP && wr && end_b > `CDPA_SP_WR_END)
                check_req = `CDPA_E_SPWR;
            else if (mt == `CDPA_MT_TC && end_w > `CDPA_TC_WORDS)
                check_req = `CDPA_E_TCREG;
            else if (mt == `CDPA_MT_IO && end_b > `CDPA_IO_BYTES)
                check_req = `CDPA_E_IOPT;
            else if (mt == `CDPA_MT_USER && end_w > `CDPA_USER_WORDS)
                check_req = `CDPA_E_SIZE;
            else if (mt == `CDPA_MT_USER && wr && run)
                check_req = `CDPA_E_PROT;
        end
    endfunction

    // maps link event flags to a code, first set flag wins
    function [7:0] link_to_code;
        input [9:0] ev;
        begin
            link_to_code = `CDPA_E_OK;
            if (ev[0])
                link_to_code = `CDPA_E_TMO;
            else if (ev[1])
                link_to_code = `CDPA_E_UNIT;
            else if (ev[2])
                link_to_code = `CDPA_E_BLKBAD;
            else if (ev[3])
                link_to_code = `CDPA_E_HDRCHR;
            else if (ev[4])
                link_to_code = `CDPA_E_BLKCHR;
            else if (ev[5])
                link_to_code = `CDPA_E_NOEOT;
            else if (ev[6])
                link_to_code = `CDPA_E_NOACK;
            else if (ev[7])
                link_to_code = `CDPA_E_CTS;
            else if (ev[8])
                link_to_code = `CDPA_E_CPU;
            else if (ev[9])
                link_to_code = `CDPA_E_TMO;
        end
    endfunction

    assign sub_word  = {sp_data[7:0], sp_data[15:8]};
    assign locked    = (pwd_reg != 16'h0000) && !login_reg;
    assign hdr_abort = hdr_fail && (hdr_try_reg == `CDPA_RETRY_MAX);
    assign blk_abort = blk_fail && (blk_try_reg == `CDPA_RETRY_MAX);
    assign conv_fin  = conv_end || hdr_abort || blk_abort;
    assign req_chk   = check_req(req_write, req_mem_type, req_addr, req_len, locked, mode_reg[0]);
    assign link_code = link_to_code(link_err);

    always @*
    begin
        if (hdr_abort)
            fin_code = `CDPA_E_HDRABT;
        else if (blk_abort)
            fin_code = `CDPA_E_BLKABT;
        else if (link_code != `CDPA_E_OK)
            fin_code = link_code;
        else if (req_valid && req_chk != `CDPA_E_OK)
            fin_code = req_chk;
        else
            fin_code = pend_code_reg;
    end

    assign diag_inc[1] = conv_fin && (fin_code == `CDPA_E_OK);
    assign diag_inc[2] = conv_fin && (fin_code != `CDPA_E_OK);
    assign diag_inc[3] = hdr_fail && !hdr_abort;
    assign diag_inc[4] = blk_fail && !blk_abort;

    // request answer and per-conversation pending code
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            req_ack       <= 1'b0;
            req_code      <= 8'h00;
            pend_code_reg <= 8'h00;
        end
        else
        begin
            req_ack <= req_valid;
            if (req_valid)
                req_code <= req_chk;
            // a refusal beats the clear at conversation start, not at conversation end
            if (req_valid && req_chk != `CDPA_E_OK && !conv_fin)
                pend_code_reg <= req_chk;
            else if (conv_start || conv_fin)
                pend_code_reg <= 8'h00;
        end
    end

    // retry counts within one conversation
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            hdr_try_reg <= 2'd0;
            blk_try_reg <= 2'd0;
            conv_abort  <= 1'b0;
        end
        else
        begin
            // abort pulse to the protocol engine
            conv_abort <= hdr_abort || blk_abort;
            if (conv_start || conv_fin)
            begin
                hdr_try_reg <= 2'd0;
                blk_try_reg <= 2'd0;
            end
            else
            begin
                if (hdr_fail)
                    hdr_try_reg <= hdr_try_reg + 2'd1;
                if (blk_fail)
                    blk_try_reg <= blk_try_reg + 2'd1;
            end
        end
    end

    // scratch-pad subcommands, password and program check
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            seq_reg    <= SEQ_IDLE;
            mode_reg   <= 16'h0000;
            result_reg <= 16'h0000;
            pwd_reg    <= 16'h0000;
            login_reg  <= 1'b0;
            chk_start  <= 1'b0;
        end
        else
        begin
            chk_start <= 1'b0;
            // a login covers one protected request
            if (req_valid && req_chk == `CDPA_E_OK && (req_mem_type == `CDPA_MT_TC
                || req_mem_type == `CDPA_MT_IO || req_mem_type == `CDPA_MT_USER))
                login_reg <= 1'b0;
            if (sp_wr && sp_addr == `CDPA_SP_MODE)
                mode_reg <= sp_data;
            case (seq_reg)
                SEQ_IDLE:
                begin
                    if (sp_wr && sp_addr == `CDPA_SP_SUBCMD)
                    begin
                        if (sub_word == `CDPA_SUB_LOGIN)
                            seq_reg <= SEQ_LOGIN;
                        else if (sub_word == `CDPA_SUB_CHPWD && login_reg)
                            seq_reg <= SEQ_CHPWD;
                        else if (sub_word == `CDPA_SUB_CHECK)
                        begin
                            chk_start <= 1'b1;
                            seq_reg   <= SEQ_CHECK;
                        end
                        else if (sub_word == `CDPA_SUB_ERRLOC)
                            result_reg <= chk_err_loc;
                    end
                end
                SEQ_LOGIN:
                begin
                    if (sp_wr && sp_addr == `CDPA_SP_PWD)
                    begin
                        login_reg <= (sp_data == pwd_reg);
                        seq_reg   <= SEQ_IDLE;
                    end
                    else if (sp_wr && sp_addr == `CDPA_SP_SUBCMD)
                        seq_reg <= SEQ_IDLE;
                end
                SEQ_CHPWD:
                begin
                    if (sp_wr && sp_addr == `CDPA_SP_PWD)
                    begin
                        if (sp_data[15:12] < 4'd10 && sp_data[11:8] < 4'd10
                            && sp_data[7:4] < 4'd10 && sp_data[3:0] < 4'd10)
                            pwd_reg <= sp_data;
                        seq_reg <= SEQ_IDLE;
                    end
                    else if (sp_wr && sp_addr == `CDPA_SP_SUBCMD)
                        seq_reg <= SEQ_IDLE;
                end
                SEQ_CHECK:
                begin
                    if (chk_done)
                    begin
                        result_reg <= chk_code;
                        seq_reg    <= SEQ_IDLE;
                    end
                end
                default:
                    seq_reg <= SEQ_IDLE;
            endcase
        end
    end

    always @(posedge core_clk)
    begin
        if (rst)
            diag_reg[0] <= 16'h0000;
        else if (conv_fin)
            diag_reg[0] <= {fin_code, diag_reg[0][15:8]};
        else if (diag_clear)
            diag_reg[0] <= 16'h0000;
    end

    // counters, a step beats a clear
    genvar g;
    generate
        for (g = 1; g < 5; g = g + 1)
        begin : cnt
            always @(posedge core_clk)
            begin
                if (rst)
                    diag_reg[g] <= 16'h0000;
                else if (diag_inc[g])
                    diag_reg[g] <= diag_reg[g] + 16'h0001;
                else if (diag_clear)
                    diag_reg[g] <= 16'h0000;
            end
        end
    endgenerate

    // read port and status outputs
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            rd_data     <= 16'h0000;
            lock_active <= 1'b0;
            run_mode    <= 1'b0;
        end
        else
        begin
            lock_active <= locked;
            run_mode    <= mode_reg[0];
            if (rd_en)
            begin
                rd_data <= 16'h0000;
                if (rd_type == `CDPA_MT_DIAG && rd_addr < 16'h0005)
                    rd_data <= diag_reg[rd_addr[2:0]];
                else if (rd_type == `CDPA_MT_SP && rd_addr == `CDPA_SP_MODE)
                    rd_data <= mode_reg;
                else if (rd_type == `CDPA_MT_SP && rd_addr == `CDPA_SP_RESULT)
                    rd_data <= result_reg;
                else if (rd_type == `CDPA_MT_SP && rd_addr == `CDPA_SP_TYPE)
                    rd_data <= `CDPA_CTRL_TYPE;
            end
        end
    end

endmodule
`default_nettype wire

// ===== verif/cdpa_core_assertions.sv
/*
 port checker for cdpa_core: request codes, scratch-pad reads, check launch.
 assumes logic/ on the include path and a single core_clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cdpa_defs.vh"
module cdpa_chk (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic [3:0]  req_mem_type,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_len,
    input wire logic        req_ack,
    input wire logic [7:0]  req_code,
    input wire logic        sp_wr,
    input wire logic [15:0] sp_addr,
    input wire logic [15:0] sp_data,
    input wire logic        rd_en,
    input wire logic [3:0]  rd_type,
    input wire logic [15:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic        chk_start,
    input wire logic        conv_abort,
    input wire logic        lock_active,
    input wire logic        run_mode
);
    wire logic [16:0] sp_end = {1'b0, req_addr} + {1'b0, req_len};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_zero_len: assert property (req_valid && req_len == 16'h0000 |=> req_ack && req_code == `CDPA_E_ZERO)
        else $error("zero length request not refused");
    a_bad_type: assert property (req_valid && req_len != 16'h0000 && !(req_mem_type inside {4'h1, 4'h3, 4'h6,
        4'h7, 4'h9}) |=> req_code == `CDPA_E_MTYPE)
        else $error("invalid memory type not refused");
    a_odd_count: assert property (req_valid && req_len != 16'h0000 && req_len[0] && req_mem_type inside {4'h1,
        4'h7, 4'h9} |=> req_code == `CDPA_E_ODD)
        else $error("odd byte count not refused");
    a_locked_deny: assert property (req_valid && req_len != 16'h0000 && !req_len[0] && lock_active &&
        $past(lock_active) && !$past(sp_wr) && req_mem_type inside {4'h1, 4'h3, 4'h7} |=> req_code == `CDPA_E_PROT)
        else $error("locked access not refused");
    a_diag_start: assert property (req_valid && req_mem_type == 4'h9 && req_len != 16'h0000 && !req_len[0] &&
        req_addr != 16'h0000 |=> req_code == `CDPA_E_DIAG)
        else $error("diagnostic start not refused");
    a_scratch_end: assert property (req_valid && req_write && req_mem_type == 4'h6 && req_len != 16'h0000 &&
        !req_addr[0] && req_addr <= 16'h0016 && sp_end > `CDPA_SP_WR_END |=> req_code == `CDPA_E_SPWR)
        else $error("scratch write past end not refused");
    a_check_go: assert property (sp_wr && sp_addr == `CDPA_SP_SUBCMD && sp_data == 16'h0300 |=> chk_start)
        else $error("program check not launched");
    a_type_read: assert property (rd_en && rd_type == 4'h6 && rd_addr == `CDPA_SP_TYPE
        |=> rd_data == `CDPA_CTRL_TYPE)
        else $error("controller type word wrong");
    a_mode_read: assert property (rd_en && rd_type == 4'h6 && rd_addr == `CDPA_SP_MODE
        |=> rd_data[0] == run_mode)
        else $error("mode word disagrees with run flag");
    a_abort_single: assert property (conv_abort |=> !conv_abort)
        else $error("abort pulse longer than one cycle");
    c_locked: cover property (req_ack && req_code == `CDPA_E_PROT);
    c_abort: cover property (conv_abort);
    c_check: cover property (chk_start);
endmodule
bind cdpa_core cdpa_chk u_chk (.core_clk, .rst, .req_valid, .req_write, .req_mem_type, .req_addr, .req_len,
    .req_ack, .req_code, .sp_wr, .sp_addr, .sp_data, .rd_en, .rd_type, .rd_addr, .rd_data, .chk_start,
    .conv_abort, .lock_active, .run_mode);
`default_nettype wire

// ===== verif/cdpa_pgm_model.sv
/*
 program checker stand-in: answers chk_start after a set delay.
 assumes core_clk domain; delay, code and location set by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module cdpa_pgm_model (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        chk_start,
    input  wire logic [7:0]  delay,
    input  wire logic [15:0] code_set,
    input  wire logic [15:0] loc_set,
    output logic             chk_done,
    output logic [15:0]      chk_code,
    output logic [15:0]      chk_err_loc
);
    logic [7:0] cnt;
    logic       busy;
    always @(posedge core_clk)
    begin
        chk_done <= 1'b0;
        chk_code <= ~chk_code;
        if (rst)
        begin
            busy <= 1'b0;
            chk_code <= 16'h5a5a;
            chk_err_loc <= 16'h0000;
        end
        else if (chk_start)
        begin
            busy <= 1'b1;
            cnt <= delay;
        end
        else if (busy && cnt != 8'h00)
            cnt <= cnt - 8'h01;
        else if (busy)
        begin
            busy <= 1'b0;
            chk_done <= 1'b1;
            chk_code <= code_set;
            chk_err_loc <= loc_set;
        end
    end
endmodule
`default_nettype wire

// ===== verif/cdpa_core_tb.sv
/*
 self-checking bench for cdpa_core with a program checker stand-in.
 assumes logic/ on the include path; inputs change at falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
`include "cdpa_defs.vh"
module cdpa_core_tb;
    logic        core_clk, rst, req_valid, req_write, req_ack, sp_wr, rd_en, diag_clear, chk_start, chk_done;
    logic        hdr_fail, blk_fail, conv_abort, conv_start, conv_end, lock_active, run_mode;
    logic [3:0]  req_mem_type, rd_type;
    logic [7:0]  req_code, m_delay, last_code;
    logic [9:0]  link_err;
    logic [15:0] req_addr, req_len, sp_addr, sp_data, rd_addr, rd_data, chk_code, chk_err_loc, m_code, m_loc;
    logic [15:0] n_ok, n_bad;
    int          mismatches, n_checks;
    cdpa_core uut (.core_clk, .rst, .req_valid, .req_write, .req_mem_type, .req_addr, .req_len, .req_ack,
        .req_code, .sp_wr, .sp_addr, .sp_data, .rd_en, .rd_type, .rd_addr, .rd_data, .diag_clear, .chk_start,
        .chk_done, .chk_code, .chk_err_loc, .hdr_fail, .blk_fail, .conv_abort, .conv_start, .conv_end,
        .link_err, .lock_active, .run_mode);
    cdpa_pgm_model u_pgm (.core_clk, .rst, .chk_start, .delay(m_delay), .code_set(m_code), .loc_set(m_loc),
        .chk_done, .chk_code, .chk_err_loc);
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic req(input logic w, input logic [3:0] t, input logic [15:0] a, l, input logic [7:0] e);
        @(negedge core_clk);
        {req_valid, req_write, req_mem_type, req_addr, req_len} = {1'b1, w, t, a, l};
        @(negedge core_clk);
        req_valid = 1'b0;
        check({15'h0000, req_ack}, 16'h0001);
        check({8'h00, req_code}, {8'h00, e});
    endtask
    task automatic spw(input logic [15:0] a, d);
        @(negedge core_clk);
        {sp_wr, sp_addr, sp_data} = {1'b1, a, d};
        @(negedge core_clk);
        sp_wr = 1'b0;
    endtask
    task automatic rd(input logic [3:0] t, input logic [15:0] a, e);
        @(negedge core_clk);
        {rd_en, rd_type, rd_addr} = {1'b1, t, a};
        @(negedge core_clk);
        rd_en = 1'b0;
        check(rd_data, e);
    endtask
    task automatic sub5(input logic [15:0] cmd, pwd);
        spw(16'h0002, cmd);
        spw(16'h0004, 16'h0000);
        spw(16'h0006, 16'h0000);
        spw(16'h0008, 16'h0000);
        spw(16'h000a, pwd);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 40 && chk_done !== 1'b1; i++)
            @(negedge core_clk);
        if (chk_done !== 1'b1)
        begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic conv(input logic [9:0] bits, input logic [7:0] e);
        @(negedge core_clk);
        conv_start = 1'b1;
        @(negedge core_clk);
        {conv_start, conv_end, link_err} = {1'b0, 1'b1, bits};
        @(negedge core_clk);
        {conv_end, link_err} = {1'b0, ~bits};
        if (e == 8'h00)
            n_ok++;
        else
            n_bad++;
        rd(4'h9, 16'h0000, {e, last_code});
        rd(4'h9, 16'h0001, n_ok);
        rd(4'h9, 16'h0002, n_bad);
        last_code = e;
    endtask
    task automatic retry(input logic hdr, input logic [7:0] e, input logic [15:0] widx);
        @(negedge core_clk);
        conv_start = 1'b1;
        @(negedge core_clk);
        {conv_start, hdr_fail, blk_fail} = {1'b0, hdr, !hdr};
        repeat (4) @(negedge core_clk);
        {hdr_fail, blk_fail} = 2'b00;
        check({15'h0000, conv_abort}, 16'h0001);
        n_bad++;
        rd(4'h9, 16'h0000, {e, last_code});
        rd(4'h9, widx, 16'h0003);
        rd(4'h9, 16'h0002, n_bad);
        last_code = e;
    endtask
    task automatic t_reset;
        rd(4'h6, 16'h0000, 16'h0000);
        rd(4'h6, 16'h0004, 16'h0000);
        rd(4'h6, 16'h0016, `CDPA_CTRL_TYPE);
        for (int i = 0; i < 5; i++)
            rd(4'h9, i[15:0], 16'h0000);
        $display("reset values done");
    endtask
    task automatic t_codes;
        req(1'b0, 4'h6, 16'h0000, 16'h0000, 8'h07);
        req(1'b0, 4'h2, 16'h0000, 16'h0002, 8'h09);
        req(1'b0, 4'h1, 16'h0000, 16'h0003, 8'h05);
        req(1'b0, 4'h9, 16'h0001, 16'h000a, 8'h0a);
        req(1'b0, 4'h9, 16'h0000, 16'h0008, 8'h0a);
        req(1'b0, 4'h6, 16'h0003, 16'h0002, 8'h0b);
        req(1'b1, 4'h6, 16'h0002, 16'h000c, 8'h02);
        req(1'b0, 4'h1, 16'h0000, 16'h0400, 8'h06);
        req(1'b0, 4'h3, 16'h0000, 16'h0100, 8'h03);
        req(1'b0, 4'h3, 16'h0001, 16'h0002, 8'h00);
        req(1'b0, 4'h7, 16'h0000, 16'h2000, 8'h04);
        req(1'b0, 4'h9, 16'h0000, 16'h000a, 8'h00);
        spw(16'h0000, 16'h0001);
        @(negedge core_clk);
        check({15'h0000, run_mode}, 16'h0001);
        req(1'b1, 4'h7, 16'h0000, 16'h0002, 8'h08);
        req(1'b0, 4'h7, 16'h0000, 16'h0002, 8'h00);
        spw(16'h0000, 16'h0000);
        $display("request codes done");
    endtask
    task automatic t_pwd;
        sub5(16'h0900, 16'h0000);
        sub5(16'h0a00, 16'h1234);
        check({15'h0000, lock_active}, 16'h0000);
        req(1'b0, 4'h1, 16'h0000, 16'h0002, 8'h00);
        repeat (2) @(negedge core_clk);
        check({15'h0000, lock_active}, 16'h0001);
        req(1'b0, 4'h1, 16'h0000, 16'h0002, 8'h08);
        req(1'b0, 4'h6, 16'h0000, 16'h0002, 8'h00);
        req(1'b0, 4'h9, 16'h0000, 16'h000a, 8'h00);
        sub5(16'h0900, 16'h3412);
        check({15'h0000, lock_active}, 16'h0001);
        sub5(16'h0900, 16'h1234);
        check({15'h0000, lock_active}, 16'h0000);
        req(1'b0, 4'h3, 16'h0000, 16'h0002, 8'h00);
        sub5(16'h0900, 16'h1234);
        sub5(16'h0a00, 16'h0000);
        req(1'b0, 4'h7, 16'h0000, 16'h0002, 8'h00);
        repeat (2) @(negedge core_clk);
        check({15'h0000, lock_active}, 16'h0000);
        $display("password done");
    endtask
    task automatic t_check;
        {m_code, m_loc, m_delay} = {16'h0025, 16'h0123, 8'h05};
        spw(16'h0002, 16'h0300);
        wait_done();
        rd(4'h6, 16'h0004, 16'h0025);
        spw(16'h0002, 16'h0600);
        rd(4'h6, 16'h0004, 16'h0123);
        m_code = 16'h0000;
        spw(16'h0002, 16'h0300);
        wait_done();
        rd(4'h6, 16'h0004, 16'h0000);
        $display("program check done");
    endtask
    task automatic t_diag;
        logic [7:0] lc [10] = '{8'h01, 8'h0f, 8'h14, 8'h1e, 8'h1f, 8'h15, 8'h16, 8'h1a, 8'h1d, 8'h01};
        conv(10'h000, 8'h00);
        for (int i = 0; i < 10; i++)
            conv(10'h001 << i, lc[i]);
        retry(1'b1, 8'h0d, 16'h0003);
        retry(1'b0, 8'h0c, 16'h0004);
        @(negedge core_clk);
        diag_clear = 1'b1;
        @(negedge core_clk);
        diag_clear = 1'b0;
        for (int i = 0; i < 5; i++)
            rd(4'h9, i[15:0], 16'h0000);
        $display("diagnostic words done");
    endtask
    task automatic t_mid_reset;
        sub5(16'h0900, 16'h0000);
        sub5(16'h0a00, 16'h0042);
        req(1'b0, 4'h1, 16'h0000, 16'h0002, 8'h00);
        spw(16'h0000, 16'h0001);
        @(negedge core_clk);
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        check({15'h0000, run_mode}, 16'h0000);
        req(1'b0, 4'h1, 16'h0000, 16'h0002, 8'h00);
        t_reset();
        $display("mid-run reset done");
    endtask
    initial
    begin
        rst = 1'b1;
        {req_valid, req_write, req_mem_type, req_addr, req_len, sp_wr, sp_addr, sp_data} = '0;
        {rd_en, rd_type, rd_addr, diag_clear, hdr_fail, blk_fail, conv_start, conv_end, link_err} = '0;
        {m_delay, m_code, m_loc, last_code, n_ok, n_bad, mismatches, n_checks} = '0;
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_codes();
        t_pwd();
        t_check();
        t_diag();
        t_mid_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
